//--- rtl/rapd_defines.svh
`ifndef RAPD_DEFINES_SVH
`define RAPD_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RAPD_OFF_PTR_HI     8'h00
`define RAPD_OFF_PTR_LO     8'h04
`define RAPD_OFF_DATA       8'h08
`define RAPD_OFF_CTRL       8'h0C
`define RAPD_OFF_CMD        8'h10
`define RAPD_OFF_IRQ_STAT   8'h14
`define RAPD_OFF_IRQ_CLR    8'h18
`define RAPD_OFF_IRQ_EN     8'h1C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RAPD_HI_RD_BIT      7
`define RAPD_HI_ADV_BIT     6
`define RAPD_HI_ARM_BIT     3
`define RAPD_CTRL_WIDE_BIT  0
`define RAPD_CTRL_MODE_BIT  1
`define RAPD_CTRL_CNT_LSB   8
`define RAPD_CTRL_CNT_MSB   18
`define RAPD_STAT_ST_LSB    8
`define RAPD_IRQ_DONE_BIT   0

// ----------------------------------------------------------------
// command codes and reset values
// ----------------------------------------------------------------
`define RAPD_CMD_CLR_DONE_MASK 8'h10
`define RAPD_RST_CNT        11'h001
`define RAPD_RST_IRQ_EN     1'b0

`endif

//--- rtl/rapd_pkg.sv
package rapd_pkg;

  typedef logic [15:0] rapd_word_t;

  // pointer high register layout
  typedef struct packed {
    logic       rd;
    logic       adv;
    logic [1:0] rsv;
    logic       arm;
    logic [2:0] addr_hi;
  } rapd_ptr_hi_t;

  typedef enum logic [1:0] {
    DMA_IDLE  = 2'b00,
    DMA_RUN   = 2'b01,
    DMA_DRAIN = 2'b10
  } rapd_dma_st_t;

endpackage : rapd_pkg

//--- rtl/rapd_ram.sv
`timescale 1ns/100ps
// 16-bit wide buffer ram, byte lanes: [15:8] odd byte, [7:0] even byte
module rapd_ram #(
  parameter int AW = 10
) (
  input  logic                      clk_in,
  input  logic [1:0]                we_in,
  input  logic [AW-1:0]             addr_in,
  input  rapd_pkg::rapd_word_t      wdata_in,
  output rapd_pkg::rapd_word_t      rdata_out
);
  import rapd_pkg::*;

  rapd_word_t mem [0:(1<<AW)-1];
  rapd_word_t rdata_r;

  always_ff @(posedge clk_in) begin
    if (we_in[0]) begin
      mem[addr_in][7:0] <= wdata_in[7:0];
    end
    if (we_in[1]) begin
      mem[addr_in][15:8] <= wdata_in[15:8];
    end
  end

  // read port samples the address every cycle
  always_ff @(posedge clk_in) begin
    rdata_r <= mem[addr_in];
  end

  assign rdata_out = rdata_r;

endmodule // rapd_ram

//--- rtl/rapd_top.sv
`timescale 1ns/100ps
`include "rapd_defines.svh"
// Function
// - pointer high read flag picks whether the next data access reads or writes
// - auto-advance flag set moves the pointer after each access, else it holds
// - request pin rises after a pointer low write only while dma arm is set
// - clearing dma arm during a transfer drops the request pin at once
// - after such a clear, the transfer ends at once, or at the next acknowledge negation if acknowledge is asserted
// - done interrupt source is the inverse of the dma arm bit
// - transfer completion clears dma arm and raises the enabled interrupt
// - ram address bits 10 to 8 come from pointer high bits 2 to 0
// - ram address bits 7 to 0 come from all of pointer low
// - in wide bus mode pointer low bit 0 acts as the byte swap control
// - swap control is left undefined by hardware reset
// - swap applies to host data cycles and dma data cycles alike
// - lane order depends on swap and on strobe style of the host
// - command 10h clears the done interrupt mask bit
module rapd_top (
  input  logic                  CLK_IN,
  input  logic                  RST_B_IN,
  input  logic                  HSEL_IN,
  input  logic [31:0]           HADDR_IN,
  input  logic [1:0]            HTRANS_IN,
  input  logic                  HWRITE_IN,
  input  logic [2:0]            HSIZE_IN,
  input  logic [31:0]           HWDATA_IN,
  input  logic                  HREADY_IN,
  output logic                  HREADYOUT_OUT,
  output logic                  HRESP_OUT,
  output logic [31:0]           HRDATA_OUT,
  input  logic                  DMA_ACK_B_IN,
  input  rapd_pkg::rapd_word_t  DMA_WDATA_IN,
  output rapd_pkg::rapd_word_t  DMA_RDATA_OUT,
  output logic                  DMA_REQ_OUT,
  output logic                  DMA_DONE_SRC_OUT,
  output logic                  IRQ_OUT
);
  import rapd_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rapd_ptr_hi_t  ptr_hi_r;
  logic [7:1]    ptr_lo_r;
  logic          swap_r;
  logic          wide_r;
  logic          mode_r;
  logic [10:0]   cnt_cfg_r;
  logic [10:0]   cnt_r;
  logic          last_r;
  rapd_dma_st_t  dma_st_r;
  rapd_dma_st_t  dma_st_nxt;
  logic          req_r;
  logic          done_src_r;
  rapd_word_t    dma_rdata_r;
  logic          irq_stat_r;
  logic          irq_en_r;
  logic          irq_r;
  logic          dph_r;
  logic          dwr_r;
  logic [7:0]    daddr_r;
  logic [1:0]    rd_ph_r;
  logic          hready_r;
  logic [31:0]   hrdata_r;
  logic          hresp_r;
  logic          ack_s1_r;
  logic          ack_s2_r;
  logic          ack_s3_r;
  logic          ack_f_r;
  logic          ack_q_r;
  rapd_word_t    dat_s1_r;
  rapd_word_t    dat_s2_r;
  rapd_word_t    dat_s3_r;

  // ----------------------------------------------------------------
  // pointer view
  // ----------------------------------------------------------------
  logic [10:0]   ptr;
  logic [10:0]   ptr_adv;
  rapd_word_t    ram_rdata;
  logic [1:0]    ram_we;
  rapd_word_t    ram_wdata;
  logic          upper_odd;
  rapd_word_t    rd_lanes;

  assign ptr = {ptr_hi_r.addr_hi, ptr_lo_r, swap_r};
  // wide mode steps by a word and keeps bit 0 as the swap control
  assign ptr_adv = wide_r ? {ptr[10:1] + 10'h001, swap_r} : ptr + 11'h001;
  // rd/wr strobe host: swap 0 puts odd on top; dir/ds host is the mirror
  assign upper_odd = ~(swap_r ^ mode_r);

  // lane swapping is its own inverse, so it serves both directions
  // mode bits come in as arguments so every caller re-evaluates when they change
  function automatic rapd_word_t lanes(input rapd_word_t w,
                                       input logic       a0,
                                       input logic       wide,
                                       input logic       uo);
    if (!wide) begin
      lanes = {8'h00, (a0 ? w[15:8] : w[7:0])};
    end else if (uo) begin
      lanes = w;
    end else begin
      lanes = {w[7:0], w[15:8]};
    end
  endfunction

  assign rd_lanes = lanes(ram_rdata, swap_r, wide_r, upper_odd);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic          take;
  logic          wr_now;
  logic          wr_hi;
  logic          wr_lo;
  logic          wr_data;
  logic          rd_done;
  logic          ack_rise;
  logic          ack_fall;
  logic          dma_step;
  logic          host_step;
  logic          abort;
  logic          dma_end;

  assign take    = HSEL_IN & HREADY_IN & HTRANS_IN[1];
  assign wr_now  = dph_r & dwr_r;
  assign wr_hi   = wr_now & (daddr_r == `RAPD_OFF_PTR_HI);
  assign wr_lo   = wr_now & (daddr_r == `RAPD_OFF_PTR_LO);
  assign wr_data = wr_now & (daddr_r == `RAPD_OFF_DATA) & ~ptr_hi_r.rd;
  assign rd_done = (rd_ph_r == 2'd2);
  assign ack_rise = ack_f_r & ~ack_q_r;
  assign ack_fall = ~ack_f_r & ack_q_r;
  assign dma_step = (dma_st_r == DMA_RUN) & ack_rise & ~abort;
  assign host_step = ~dma_step & (wr_data |
                     (rd_done & (daddr_r == `RAPD_OFF_DATA) & ptr_hi_r.rd));
  assign abort = wr_hi & ~HWDATA_IN[`RAPD_HI_ARM_BIT] & (dma_st_r != DMA_IDLE);
  assign dma_end = (dma_st_r != DMA_IDLE) & (dma_st_nxt == DMA_IDLE);

  // ----------------------------------------------------------------
  // ram port
  // ----------------------------------------------------------------
  always_comb begin
    ram_we    = 2'b00;
    ram_wdata = dma_step ? dat_s3_r : HWDATA_IN[15:0];
    if (!wide_r) begin
      // a narrow byte always arrives on the low lane; copy it to both
      ram_wdata = {ram_wdata[7:0], ram_wdata[7:0]};
    end else begin
      ram_wdata = lanes(ram_wdata, swap_r, wide_r, upper_odd);
    end
    if ((dma_step & ~ptr_hi_r.rd) | (~dma_step & wr_data)) begin
      ram_we = !wide_r ? (swap_r ? 2'b10 : 2'b01) : 2'b11;
    end
  end

  rapd_ram #(
    .AW (10)
  ) u_ram (
    .clk_in    (CLK_IN),
    .we_in     (ram_we),
    .addr_in   (ptr[10:1]),
    .wdata_in  (ram_wdata),
    .rdata_out (ram_rdata)
  );

  // ----------------------------------------------------------------
  // acknowledge and data pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_s3_r <= 1'b0;
      ack_f_r  <= 1'b0;
      ack_q_r  <= 1'b0;
    end else begin
      ack_s1_r <= ~DMA_ACK_B_IN;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
      ack_q_r  <= ack_f_r;
      if (ack_s2_r == ack_s3_r) begin
        ack_f_r <= ack_s3_r;
      end
    end
  end

  // data is only looked at on an acknowledge edge, long after it settles
  always_ff @(posedge CLK_IN) begin
    dat_s1_r <= DMA_WDATA_IN;
    dat_s2_r <= dat_s1_r;
    dat_s3_r <= dat_s2_r;
  end

  // ----------------------------------------------------------------
  // pointer registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      ptr_hi_r <= '0;
      ptr_lo_r <= '0;
    end else begin
      if (wr_hi) begin
        ptr_hi_r.rd      <= HWDATA_IN[`RAPD_HI_RD_BIT];
        ptr_hi_r.adv     <= HWDATA_IN[`RAPD_HI_ADV_BIT];
        ptr_hi_r.addr_hi <= HWDATA_IN[2:0];
      end else if ((dma_step | host_step) & ptr_hi_r.adv) begin
        ptr_hi_r.addr_hi <= ptr_adv[10:8];
      end
      // completion wins over a host write of the arm bit
      if (dma_end & ~abort) begin
        ptr_hi_r.arm <= 1'b0;
      end else if (wr_hi) begin
        ptr_hi_r.arm <= HWDATA_IN[`RAPD_HI_ARM_BIT];
      end
      if (wr_lo) begin
        ptr_lo_r <= HWDATA_IN[7:1];
      end else if ((dma_step | host_step) & ptr_hi_r.adv) begin
        ptr_lo_r <= ptr_adv[7:1];
      end
    end
  end

  // no reset on purpose: swap is undefined until software writes it
  always_ff @(posedge CLK_IN) begin
    if (wr_lo) begin
      swap_r <= HWDATA_IN[0];
    end else if ((dma_step | host_step) & ptr_hi_r.adv) begin
      swap_r <= ptr_adv[0];
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      wide_r    <= 1'b0;
      mode_r    <= 1'b0;
      cnt_cfg_r <= `RAPD_RST_CNT;
    end else if (wr_now && daddr_r == `RAPD_OFF_CTRL) begin
      wide_r    <= HWDATA_IN[`RAPD_CTRL_WIDE_BIT];
      mode_r    <= HWDATA_IN[`RAPD_CTRL_MODE_BIT];
      cnt_cfg_r <= HWDATA_IN[`RAPD_CTRL_CNT_MSB:`RAPD_CTRL_CNT_LSB];
    end
  end

  // ----------------------------------------------------------------
  // dma sequencer
  // ----------------------------------------------------------------
  always_comb begin
    dma_st_nxt = dma_st_r;
    case (dma_st_r)
      DMA_IDLE: begin
        if (wr_lo && ptr_hi_r.arm) begin
          dma_st_nxt = DMA_RUN;
        end
      end
      DMA_RUN: begin
        if (abort) begin
          dma_st_nxt = ack_f_r ? DMA_DRAIN : DMA_IDLE;
        end else if (ack_fall && last_r) begin
          dma_st_nxt = DMA_IDLE;
        end
      end
      DMA_DRAIN: begin
        if (ack_fall) begin
          dma_st_nxt = DMA_IDLE;
        end
      end
      default: begin
        dma_st_nxt = DMA_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      dma_st_r <= DMA_IDLE;
      req_r    <= 1'b0;
      cnt_r    <= '0;
      last_r   <= 1'b0;
    end else begin
      dma_st_r <= dma_st_nxt;
      if (dma_st_r == DMA_IDLE && dma_st_nxt == DMA_RUN) begin
        req_r  <= 1'b1;
        cnt_r  <= cnt_cfg_r;
        last_r <= 1'b0;
      end else if (abort) begin
        req_r <= 1'b0;
      end else if (dma_step) begin
        cnt_r <= cnt_r - 11'h001;
        if (cnt_r == 11'h001) begin
          req_r  <= 1'b0;
          last_r <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      dma_rdata_r <= '0;
    end else if (dma_step && ptr_hi_r.rd) begin
      dma_rdata_r <= rd_lanes;
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      done_src_r <= 1'b1;
      irq_stat_r <= 1'b0;
      irq_en_r   <= `RAPD_RST_IRQ_EN;
      irq_r      <= 1'b0;
    end else begin
      done_src_r <= ~((dma_end & ~abort) ? 1'b0 :
                      (wr_hi ? HWDATA_IN[`RAPD_HI_ARM_BIT] : ptr_hi_r.arm));
      if (dma_end) begin
        irq_stat_r <= 1'b1;
      end else if (wr_now && daddr_r == `RAPD_OFF_IRQ_CLR &&
                   HWDATA_IN[`RAPD_IRQ_DONE_BIT]) begin
        irq_stat_r <= 1'b0;
      end
      if (wr_now && daddr_r == `RAPD_OFF_CMD &&
          HWDATA_IN[7:0] == `RAPD_CMD_CLR_DONE_MASK) begin
        irq_en_r <= 1'b0;
      end else if (wr_now && daddr_r == `RAPD_OFF_IRQ_EN) begin
        irq_en_r <= HWDATA_IN[`RAPD_IRQ_DONE_BIT];
      end
      irq_r <= irq_stat_r & irq_en_r;
    end
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (daddr_r)
      `RAPD_OFF_PTR_HI:   rd_mux[7:0] = ptr_hi_r;
      `RAPD_OFF_PTR_LO:   rd_mux[7:0] = {ptr_lo_r, swap_r};
      `RAPD_OFF_DATA:     rd_mux[15:0] = ptr_hi_r.rd ? rd_lanes : 16'h0000;
      `RAPD_OFF_CTRL: begin
        rd_mux[`RAPD_CTRL_WIDE_BIT] = wide_r;
        rd_mux[`RAPD_CTRL_MODE_BIT] = mode_r;
        rd_mux[`RAPD_CTRL_CNT_MSB:`RAPD_CTRL_CNT_LSB] = cnt_cfg_r;
      end
      `RAPD_OFF_IRQ_STAT: begin
        rd_mux[`RAPD_IRQ_DONE_BIT] = irq_stat_r;
        rd_mux[`RAPD_STAT_ST_LSB+1:`RAPD_STAT_ST_LSB] = dma_st_r;
      end
      `RAPD_OFF_IRQ_EN:   rd_mux[`RAPD_IRQ_DONE_BIT] = irq_en_r;
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  // reads wait two cycles so a preceding write and the ram read settle
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      dph_r    <= 1'b0;
      dwr_r    <= 1'b0;
      daddr_r  <= '0;
      rd_ph_r  <= 2'd0;
      hready_r <= 1'b1;
      hrdata_r <= '0;
      hresp_r  <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
      if (rd_ph_r == 2'd1) begin
        rd_ph_r <= 2'd2;
      end else if (rd_done) begin
        rd_ph_r  <= 2'd0;
        hready_r <= 1'b1;
        hrdata_r <= rd_mux;
      end
      if (hready_r) begin
        dph_r <= take;
        dwr_r <= HWRITE_IN;
        if (take) begin
          daddr_r <= HADDR_IN[7:0] & 8'hFC;
          if (HADDR_IN[31:8] != 24'h000000) begin
            daddr_r <= 8'hFC;
          end
          if (!HWRITE_IN) begin
            rd_ph_r  <= 2'd1;
            hready_r <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign HREADYOUT_OUT    = hready_r;
  assign HRESP_OUT        = hresp_r;
  assign HRDATA_OUT       = hrdata_r;
  assign DMA_RDATA_OUT    = dma_rdata_r;
  assign DMA_REQ_OUT      = req_r;
  assign DMA_DONE_SRC_OUT = done_src_r;
  assign IRQ_OUT          = irq_r;

endmodule // rapd_top

//--- testbench/rapd_checker.sv
`timescale 1ns/100ps
module rapd_checker (
  input logic        CLK_IN,
  input logic        RST_B_IN,
  input logic        HSEL_IN,
  input logic [31:0] HADDR_IN,
  input logic [1:0]  HTRANS_IN,
  input logic        HWRITE_IN,
  input logic [31:0] HWDATA_IN,
  input logic        HREADY_IN,
  input logic        HREADYOUT_OUT,
  input logic        DMA_REQ_OUT,
  input logic        DMA_DONE_SRC_OUT,
  input logic        IRQ_OUT
);
  logic lo_r;
  logic hi_r;
  logic cmd_r;
  wire  take_w = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  wire  wr_w   = take_w && HWRITE_IN && (HADDR_IN[31:8] == 24'h0);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // ----
  // write data phase markers
  // ----
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      lo_r  <= 1'b0;
      hi_r  <= 1'b0;
      cmd_r <= 1'b0;
    end else begin
      lo_r  <= wr_w && (HADDR_IN[7:0] == 8'h04);
      hi_r  <= wr_w && (HADDR_IN[7:0] == 8'h00);
      cmd_r <= wr_w && (HADDR_IN[7:0] == 8'h10);
    end
  end
  sequence s_rd_take;
    take_w && !HWRITE_IN;
  endsequence
  sequence s_rd_wait;
    !HREADYOUT_OUT [*2] ##1 HREADYOUT_OUT;
  endsequence
  a_read_wait: assert property (s_rd_take |=> s_rd_wait)
    else $error("read wait not two cycles");
  a_write_nowait: assert property (take_w && HWRITE_IN |=> HREADYOUT_OUT)
    else $error("write stalled");
  a_reset_quiet: assert property ($rose(RST_B_IN) |-> !DMA_REQ_OUT && DMA_DONE_SRC_OUT)
    else $error("request or done wrong after reset");
  a_req_cause: assert property ($rose(DMA_REQ_OUT) |-> $past(lo_r))
    else $error("request without pointer low write");
  a_req_armed: assert property (DMA_REQ_OUT |-> !DMA_DONE_SRC_OUT)
    else $error("done source high while requesting");
  a_abort_drop: assert property (hi_r && !HWDATA_IN[3] && DMA_REQ_OUT |=> !DMA_REQ_OUT)
    else $error("request kept after disarm");
  a_irq_rise: assert property ($rose(IRQ_OUT) |-> DMA_DONE_SRC_OUT && !DMA_REQ_OUT)
    else $error("irq before transfer end");
  a_mask_clear: assert property (cmd_r && HWDATA_IN[7:0] == 8'h10 |-> ##[1:2] !IRQ_OUT)
    else $error("irq kept after mask command");
endmodule // rapd_checker

//--- testbench/rapd_dma_model.sv
`timescale 1ns/100ps
module rapd_dma_model (
  input  wire logic           clk_in,
  input  wire logic           rst_b_in,
  input  wire logic           req_in,
  input  wire logic           en_in,
  input  wire logic           kick_in,
  input  rapd_pkg::rapd_word_t rdata_in,
  output logic                ack_b_out,
  output rapd_pkg::rapd_word_t wdata_out
);
  import rapd_pkg::*;
  logic [7:0] cnt_r;
  logic [7:0] n_log;
  rapd_word_t log_r [0:3];
  // ----
  // acknowledge cycles, low phases of 9 clocks and high phases of at least 9 clocks
  // ----
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ack_b_out <= 1'b1;
      cnt_r     <= 8'h00;
      n_log     <= 8'h00;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end else if (!ack_b_out) begin
      log_r[n_log[1:0]] <= rdata_in;
      n_log             <= n_log + 8'h01;
      ack_b_out         <= 1'b1;
      cnt_r             <= 8'h08;
    end else if (en_in && (req_in || kick_in)) begin
      ack_b_out <= 1'b0;
      cnt_r     <= 8'h08;
    end
  end
  // released data lines keep changing so stale data is not mistaken
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wdata_out <= 16'h0000;
    end else if (ack_b_out) begin
      wdata_out <= wdata_out + 16'h1111;
    end
  end
endmodule // rapd_dma_model

//--- testbench/rapd_bench.sv
`timescale 1ns/100ps
module rapd_bench;
  import rapd_pkg::*;
  logic        clk, rst_b, hsel, hwrite, hready, hresp;
  logic        en, kick, ack_b, dma_request_pin, dsrc, irq;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  rapd_word_t  dwd, drd;
  int          num_errors, n_tests;
  rapd_top DUT (.CLK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .HRDATA_OUT(hrdata), .DMA_ACK_B_IN(ack_b), .DMA_WDATA_IN(dwd),
    .DMA_RDATA_OUT(drd), .DMA_REQ_OUT(dma_request_pin), .DMA_DONE_SRC_OUT(dsrc), .IRQ_OUT(irq));
  rapd_dma_model u_dma (.clk_in(clk), .rst_b_in(rst_b), .req_in(dma_request_pin), .en_in(en),
    .kick_in(kick), .rdata_in(drd), .ack_b_out(ack_b), .wdata_out(dwd));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (!hready) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (!hready) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic t_regs;
    rdc(32'h00, 32'h00);
    chk(hresp, 0);
    rdc(32'h0C, 32'h100);
    rdc(32'h14, 32'h00);
    wr(32'h100, 32'hFF);
    rdc(32'h100, 32'h00);
    wr(32'h00, 32'h45);
    rdc(32'h00, 32'h45);
    wr(32'h04, 32'hA7);
    rdc(32'h04, 32'hA7);
    $display("regs done");
  endtask
  task automatic t_host;
    logic [10:0] ad [4] = '{11'h5FF, 11'h1FF, 11'h010, 11'h011};
    logic [7:0]  dv [4] = '{8'hC3, 8'h3C, 8'hA1, 8'hB2};
    for (int i = 0; i < 4; i++) begin
      wr(32'h00, {29'h0, ad[i][10:8]});
      wr(32'h04, {24'h0, ad[i][7:0]});
      wr(32'h08, {24'h0, dv[i]});
    end
    for (int i = 0; i < 2; i++) begin
      wr(32'h00, {24'h0, 5'h10, ad[i][10:8]});
      wr(32'h04, {24'h0, ad[i][7:0]});
      rdc(32'h08, {24'h0, dv[i]});
    end
    wr(32'h00, 32'hC0);
    wr(32'h04, 32'h10);
    rdc(32'h08, 32'hA1);
    rdc(32'h08, 32'hB2);
    rdc(32'h04, 32'h12);
    wr(32'h00, 32'h80);
    wr(32'h04, 32'h10);
    wr(32'h08, 32'h55);
    rdc(32'h08, 32'hA1);
    rdc(32'h08, 32'hA1);
    $display("host done");
  endtask
  task automatic t_swap;
    wr(32'h0C, 32'h100);
    wr(32'h00, 32'h40);
    wr(32'h04, 32'h20);
    wr(32'h0C, 32'h101);
    wr(32'h08, 32'h1234);
    wr(32'h08, 32'h5678);
    for (int k = 0; k < 4; k++) begin
      wr(32'h0C, 32'h100);
      wr(32'h00, 32'h80);
      wr(32'h04, 32'h20 | k[0]);
      wr(32'h0C, 32'h101 | {k[1], 1'b0});
      rdc(32'h08, (k[0] ^ k[1]) ? 32'h3412 : 32'h1234);
    end
    $display("swap done");
  endtask
  task automatic t_dma;
    wr(32'h0C, 32'h200);
    wr(32'h1C, 32'h1);
    wr(32'h00, 32'hC0);
    wr(32'h04, 32'h21);
    wr(32'h0C, 32'h201);
    wr(32'h00, 32'hC8);
    wr(32'h04, 32'h21);
    @(posedge clk);
    chk(dma_request_pin, 1);
    for (int i = 0; i < 200 && dsrc !== 1'b1; i++) @(posedge clk);
    chk(u_dma.log_r[0], 16'h3412);
    chk(u_dma.log_r[1], 16'h7856);
    chk(u_dma.n_log, 2);
    chk(dma_request_pin, 0);
    rdc(32'h00, 32'hC0);
    rdc(32'h14, 32'h1);
    chk(irq, 1);
    ahb(1'b0, 32'h04, 32'h0);
    chk(rd & 32'hFE, 32'h24);
    wr(32'h10, 32'h10);
    rdc(32'h1C, 32'h0);
    chk(irq, 0);
    wr(32'h18, 32'h1);
    rdc(32'h14, 32'h0);
    $display("dma done");
  endtask
  task automatic t_abort;
    rapd_word_t expd;
    en <= 1'b0;
    wr(32'h0C, 32'h400);
    wr(32'h00, 32'h40);
    wr(32'h04, 32'h30);
    repeat (4) @(posedge clk);
    chk(dma_request_pin, 0);
    wr(32'h00, 32'h48);
    wr(32'h04, 32'h30);
    @(posedge clk);
    chk(dma_request_pin, 1);
    wr(32'h00, 32'h40);
    @(posedge clk);
    chk(dma_request_pin, 0);
    chk(dsrc, 1);
    rdc(32'h14, 32'h1);
    en <= 1'b1;
    kick <= 1'b1;
    @(posedge clk);
    en <= 1'b0;
    kick <= 1'b0;
    for (int i = 0; i < 20 && ack_b !== 1'b0; i++) @(posedge clk);
    chk(dsrc, 1);
    for (int i = 0; i < 40 && ack_b !== 1'b1; i++) @(posedge clk);
    rdc(32'h14, 32'h1);
    wr(32'h18, 32'h1);
    wr(32'h1C, 32'h1);
    en <= 1'b1;
    wr(32'h00, 32'h48);
    wr(32'h04, 32'h30);
    for (int i = 0; i < 20 && ack_b !== 1'b0; i++) @(posedge clk);
    repeat (6) @(posedge clk);
    expd = dwd;
    wr(32'h00, 32'h40);
    @(posedge clk);
    chk(irq, 0);
    chk(dma_request_pin, 0);
    chk(dsrc, 1);
    for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge clk);
    chk(ack_b, 1);
    rdc(32'h14, 32'h1);
    en <= 1'b0;
    rdc(32'h04, 32'h31);
    wr(32'h00, 32'h80);
    wr(32'h04, 32'h30);
    rdc(32'h08, {24'h0, expd[7:0]});
    wr(32'h18, 32'h1);
    $display("abort done");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict;
  end
  initial begin
    {rst_b, hsel, hwrite, kick} = 4'h0;
    en = 1'b1;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    num_errors = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs;
    t_host;
    t_swap;
    t_dma;
    t_abort;
    print_verdict;
  end
endmodule // rapd_bench
bind rapd_top rapd_checker u_chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .HSEL_IN(HSEL_IN),
  .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HWDATA_IN(HWDATA_IN),
  .HREADY_IN(HREADY_IN), .HREADYOUT_OUT(HREADYOUT_OUT), .DMA_REQ_OUT(DMA_REQ_OUT),
  .DMA_DONE_SRC_OUT(DMA_DONE_SRC_OUT), .IRQ_OUT(IRQ_OUT));
